/* rtl/dcfg_top.v */
// device configuration block: timer, sampling, soft reset, sleep, id, eeprom port, pins
//
// Contract
// - sixteen-bit down counter, crystal or external clock
// - bit0 enables timer interrupt; control read clears
// - bit1 zero pauses, one starts counter
// - bit2 zero retriggers, one gives one-shot
// - bit3 selects crystal or external clock pin
// - bit4 routes timer interrupt to output pin0
// - reload value low/high bytes, default zero
// - timer time-out reported in channel 0 code
// - one sampling bit per channel, one is 8X
// - soft reset bit pulses channel reset, self-clears
// - sleep only when every idle condition holds
// - oscillator stops asleep, all eight enables set
// - wake on rx start, tx load, modem change
// - re-sleep after service; never while interrupt pending
// - ready after 32 crystal clocks; special interrupt
// - identifier: family nibble, channel count nibble
// - read-only revision code
// - bit16 broadcasts writes; 19..17 reserved
// - write-only bits drive eeprom clock, select, data
// - bit23 reads eeprom data-out pin level
// - pins: inverted input or driven output; ORed interrupt
// - pin interrupt edge-sensed, inputs only, level-read clears
// - direction bit one is input, reset all ones
// - tristate bit one floats output pin
// - timer code seven, pin code six
`timescale 1ns/1ps
module dcfg_top #(
    parameter [3:0] FAMILY_CODE   = 4'h5,   // arbitrary value
    parameter [3:0] CHANNEL_COUNT = 4'h8,
    parameter [7:0] REVISION_CODE = 8'h07   // arbitrary value
) (
    // clock and reset
    input  wire        clk_sys,
    input  wire        rst,
    // register port, byte wide
    input  wire [7:0]  reg_addr,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    output reg         reg_rvalid,
    // timer clocks
    input  wire        crystal_tick,
    input  wire        external_timer_clock_pin,
    // channel configuration outputs
    output reg  [7:0]  sampling_rate_select,
    output reg  [7:0]  channel_reset_pulse,
    output reg         broadcast_write,
    output reg  [2:0]  chan0_int_code,
    // channel status for sleep
    input  wire [7:0]  chan_int_pending,
    input  wire [7:0]  divisor_nonzero,
    input  wire [7:0]  modem_delta_flag,
    input  wire [7:0]  rx_input,
    input  wire [7:0]  tx_load,
    input  wire [7:0]  modem_input_change,
    input  wire        int_indicator_read,
    // sleep state
    output reg         asleep,
    output reg         oscillator_enable,
    output reg         device_ready,
    output reg         wake_interrupt,
    // serial eeprom
    output reg         eeprom_clock_out,
    output reg         eeprom_select_out,
    output reg         eeprom_data_to_memory,
    input  wire        eeprom_data_from_memory,
    // multipurpose pins
    input  wire [7:0]  multipurpose_pins_in,
    output reg  [7:0]  multipurpose_pins_out,
    output reg  [7:0]  multipurpose_pins_oe
);
`include "dcfg_defines.vh"

    localparam [1:0] ST_AWAKE  = 2'h0;
    localparam [1:0] ST_ASLEEP = 2'h1;
    localparam [1:0] ST_WAKING = 2'h2;

    reg  [7:0]  timer_control_reg;
    reg  [15:0] timer_reload_reg;
    reg  [7:0]  sleep_enable_reg;
    reg  [7:0]  pin_interrupt_enable_reg;
    reg  [7:0]  pin_level_reg;
    reg  [7:0]  pin_output_tristate_reg;
    reg  [7:0]  pin_input_invert_reg;
    reg  [7:0]  pin_direction_reg;
    reg         timer_pending_reg;
    reg         pin_pending_reg;
    reg         ext_clk_prev_reg;
    reg  [7:0]  rx_prev_reg;
    reg  [7:0]  pin_active_prev_reg;
    reg  [1:0]  sleep_state_reg;
    reg  [5:0]  wake_count_reg;
    reg         timer_restart_reg;
    reg  [7:0]  rdata_next;

    wire        wr_timer_control;
    wire        rd_timer_control;
    wire        rd_pin_level;
    wire        timer_tick;
    wire        timer_timeout;
    wire [7:0]  pin_active;
    wire [7:0]  pin_edge;
    wire [7:0]  pin_level_view;
    wire        timer_int_live;
    wire        sleep_allowed;
    wire        wake_event;

    assign wr_timer_control = reg_wr && (reg_addr == `DCFG_ADDR_TIMER_CONTROL);
    assign rd_timer_control = reg_rd && (reg_addr == `DCFG_ADDR_TIMER_CONTROL);
    assign rd_pin_level     = reg_rd && (reg_addr == `DCFG_ADDR_PIN_LEVEL);

    // ------------------------------------------------------------
    // timer clock select
    // ------------------------------------------------------------
    // the external pin is counted on its rising edge at clk_sys rate,
    // so it must stay below half of clk_sys
    assign timer_tick = timer_control_reg[`DCFG_TC_EXT_CLK] ?
                        (external_timer_clock_pin && !ext_clk_prev_reg) :
                        crystal_tick;

    dcfg_timer u_timer (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .count_tick  (timer_tick),
        .run         (timer_control_reg[`DCFG_TC_RUN]),
        .one_shot    (timer_control_reg[`DCFG_TC_ONE_SHOT]),
        .restart     (timer_restart_reg),
        .reload      (timer_reload_reg),
        .timeout_reg (timer_timeout)
    );

    assign timer_int_live = timer_pending_reg && timer_control_reg[`DCFG_TC_INT_EN];

    // ------------------------------------------------------------
    // pin interrupt sensing
    // ------------------------------------------------------------
    // a pin is active when its corrected input equals its level bit;
    // only the rising of that comparison raises the interrupt
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
            assign pin_active[gi] = pin_direction_reg[gi] && pin_interrupt_enable_reg[gi] &&
                                    ((multipurpose_pins_in[gi] ^ pin_input_invert_reg[gi]) ==
                                     pin_level_reg[gi]);
            assign pin_edge[gi] = pin_active[gi] && !pin_active_prev_reg[gi];
            assign pin_level_view[gi] = pin_direction_reg[gi] ?
                                        (multipurpose_pins_in[gi] ^ pin_input_invert_reg[gi]) :
                                        pin_level_reg[gi];
        end
    endgenerate

    // ------------------------------------------------------------
    // sleep conditions
    // ------------------------------------------------------------
    assign sleep_allowed = (chan_int_pending == 8'h00) && (divisor_nonzero == 8'hff) &&
                           (sleep_enable_reg == 8'hff) && (modem_delta_flag == 8'h00) &&
                           (rx_input == 8'hff) && !wake_interrupt &&
                           !timer_int_live && !pin_pending_reg;
    assign wake_event = ((rx_prev_reg & ~rx_input) != 8'h00) ||
                        (tx_load != 8'h00) || (modem_input_change != 8'h00);

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            timer_control_reg        <= `DCFG_RST_BYTE_ZERO;
            timer_reload_reg         <= `DCFG_RST_TIMER_VALUE;
            sampling_rate_select     <= `DCFG_RST_BYTE_ZERO;
            channel_reset_pulse      <= `DCFG_RST_BYTE_ZERO;
            sleep_enable_reg         <= `DCFG_RST_BYTE_ZERO;
            broadcast_write          <= 1'b0;
            eeprom_clock_out         <= 1'b0;
            eeprom_select_out        <= 1'b0;
            eeprom_data_to_memory    <= 1'b0;
            pin_interrupt_enable_reg <= `DCFG_RST_BYTE_ZERO;
            pin_level_reg            <= `DCFG_RST_BYTE_ZERO;
            pin_output_tristate_reg  <= `DCFG_RST_BYTE_ZERO;
            pin_input_invert_reg     <= `DCFG_RST_BYTE_ZERO;
            pin_direction_reg        <= `DCFG_RST_PIN_DIRECTION;
            timer_restart_reg        <= 1'b0;
        end else begin
            channel_reset_pulse <= `DCFG_RST_BYTE_ZERO;
            timer_restart_reg   <= 1'b0;
            if (reg_wr) begin
                if (reg_addr == `DCFG_ADDR_TIMER_CONTROL) begin
                    timer_control_reg <= reg_wdata & `DCFG_TC_USED_MASK;
                    timer_restart_reg <= reg_wdata[`DCFG_TC_RUN];
                end else if (reg_addr == `DCFG_ADDR_TIMER_LOW) begin
                    timer_reload_reg[7:0] <= reg_wdata;
                end else if (reg_addr == `DCFG_ADDR_TIMER_HIGH) begin
                    timer_reload_reg[15:8] <= reg_wdata;
                end else if (reg_addr == `DCFG_ADDR_SAMPLING) begin
                    sampling_rate_select <= reg_wdata;
                end else if (reg_addr == `DCFG_ADDR_SOFT_RESET) begin
                    channel_reset_pulse <= reg_wdata;
                end else if (reg_addr == `DCFG_ADDR_SLEEP) begin
                    sleep_enable_reg <= reg_wdata;
                end else if (reg_addr == `DCFG_ADDR_BCAST_EEPROM) begin
                    broadcast_write       <= reg_wdata[`DCFG_BE_BROADCAST];
                    eeprom_clock_out      <= reg_wdata[`DCFG_BE_EE_CLOCK];
                    eeprom_select_out     <= reg_wdata[`DCFG_BE_EE_SELECT];
                    eeprom_data_to_memory <= reg_wdata[`DCFG_BE_EE_DATA_TO];
                end else if (reg_addr == `DCFG_ADDR_PIN_INT_EN) begin
                    pin_interrupt_enable_reg <= reg_wdata;
                end else if (reg_addr == `DCFG_ADDR_PIN_LEVEL) begin
                    pin_level_reg <= reg_wdata;
                end else if (reg_addr == `DCFG_ADDR_PIN_TRISTATE) begin
                    pin_output_tristate_reg <= reg_wdata;
                end else if (reg_addr == `DCFG_ADDR_PIN_INVERT) begin
                    pin_input_invert_reg <= reg_wdata;
                end else if (reg_addr == `DCFG_ADDR_PIN_DIRECTION) begin
                    pin_direction_reg <= reg_wdata;
                end
                // reserved, read-only and unmapped offsets ignore writes
            end
        end
    end

    // ------------------------------------------------------------
    // read data mux
    // ------------------------------------------------------------
    always @* begin
        rdata_next = 8'h00;
        if (reg_addr == `DCFG_ADDR_TIMER_CONTROL) begin
            rdata_next = timer_control_reg;
        end else if (reg_addr == `DCFG_ADDR_TIMER_LOW) begin
            rdata_next = timer_reload_reg[7:0];
        end else if (reg_addr == `DCFG_ADDR_TIMER_HIGH) begin
            rdata_next = timer_reload_reg[15:8];
        end else if (reg_addr == `DCFG_ADDR_SAMPLING) begin
            rdata_next = sampling_rate_select;
        end else if (reg_addr == `DCFG_ADDR_SLEEP) begin
            rdata_next = sleep_enable_reg;
        end else if (reg_addr == `DCFG_ADDR_REVISION) begin
            rdata_next = REVISION_CODE;
        end else if (reg_addr == `DCFG_ADDR_IDENTIFIER) begin
            rdata_next = {FAMILY_CODE, CHANNEL_COUNT};
        end else if (reg_addr == `DCFG_ADDR_BCAST_EEPROM) begin
            rdata_next = {eeprom_data_from_memory, 6'h00, broadcast_write};
        end else if (reg_addr == `DCFG_ADDR_PIN_INT_EN) begin
            rdata_next = pin_interrupt_enable_reg;
        end else if (reg_addr == `DCFG_ADDR_PIN_LEVEL) begin
            rdata_next = pin_level_view;
        end else if (reg_addr == `DCFG_ADDR_PIN_TRISTATE) begin
            rdata_next = pin_output_tristate_reg;
        end else if (reg_addr == `DCFG_ADDR_PIN_INVERT) begin
            rdata_next = pin_input_invert_reg;
        end else if (reg_addr == `DCFG_ADDR_PIN_DIRECTION) begin
            rdata_next = pin_direction_reg;
        end
    end

    // registered read answer, one cycle after the strobe
    always @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rdata_next;
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt flags and channel 0 code
    // ------------------------------------------------------------
    // set wins over a clearing read in the same cycle so no event is lost
    always @(posedge clk_sys) begin
        if (rst) begin
            timer_pending_reg   <= 1'b0;
            pin_pending_reg     <= 1'b0;
            ext_clk_prev_reg    <= 1'b0;
            pin_active_prev_reg <= 8'h00;
            chan0_int_code      <= `DCFG_CODE_NONE;
        end else begin
            ext_clk_prev_reg    <= external_timer_clock_pin;
            pin_active_prev_reg <= pin_active;
            if (timer_timeout) begin
                timer_pending_reg <= 1'b1;
            end else if (rd_timer_control) begin
                timer_pending_reg <= 1'b0;
            end
            if (pin_edge != 8'h00) begin
                pin_pending_reg <= 1'b1;
            end else if (rd_pin_level) begin
                pin_pending_reg <= 1'b0;
            end
            // pin source outranks the timer, which has the lowest priority
            if (pin_pending_reg) begin
                chan0_int_code <= `DCFG_CODE_PIN;
            end else if (timer_int_live) begin
                chan0_int_code <= `DCFG_CODE_TIMER;
            end else begin
                chan0_int_code <= `DCFG_CODE_NONE;
            end
        end
    end

    // ------------------------------------------------------------
    // multipurpose pin drivers
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            multipurpose_pins_out <= 8'h00;
            multipurpose_pins_oe  <= 8'h00;
        end else begin
            multipurpose_pins_oe  <= ~pin_direction_reg & ~pin_output_tristate_reg;
            multipurpose_pins_out <= pin_level_reg;
            if (timer_control_reg[`DCFG_TC_ROUTE_PIN0] && !pin_direction_reg[0]) begin
                multipurpose_pins_out[0] <= timer_int_live;
            end
        end
    end

    // ------------------------------------------------------------
    // sleep state machine
    // ------------------------------------------------------------
    // crystal ticks pause while asleep, so the ready count only runs
    // once the oscillator is back
    always @(posedge clk_sys) begin
        if (rst) begin
            sleep_state_reg   <= ST_AWAKE;
            wake_count_reg    <= 6'h00;
            rx_prev_reg       <= 8'hff;
            asleep            <= 1'b0;
            oscillator_enable <= 1'b1;
            device_ready      <= 1'b1;
            wake_interrupt    <= 1'b0;
        end else begin
            rx_prev_reg <= rx_input;
            if (int_indicator_read) begin
                wake_interrupt <= 1'b0;
            end
            case (sleep_state_reg)
                ST_AWAKE: begin
                    if (sleep_allowed) begin
                        sleep_state_reg   <= ST_ASLEEP;
                        asleep            <= 1'b1;
                        oscillator_enable <= 1'b0;
                        device_ready      <= 1'b0;
                    end
                end
                ST_ASLEEP: begin
                    if (wake_event || sleep_enable_reg != 8'hff) begin
                        sleep_state_reg   <= ST_WAKING;
                        asleep            <= 1'b0;
                        oscillator_enable <= 1'b1;
                        wake_count_reg    <= 6'h00;
                        wake_interrupt    <= 1'b1;
                    end
                end
                ST_WAKING: begin
                    if (crystal_tick) begin
                        if (wake_count_reg == `DCFG_WAKE_CRYSTAL_CLOCKS - 6'h01) begin
                            sleep_state_reg <= ST_AWAKE;
                            device_ready    <= 1'b1;
                        end else begin
                            wake_count_reg <= wake_count_reg + 6'h01;
                        end
                    end
                end
                default: begin
                    sleep_state_reg <= ST_AWAKE;
                end
            endcase
        end
    end

endmodule

/* rtl/dcfg_defines.vh */
// constants for the device configuration block: offsets, fields, resets, timing
`ifndef DCFG_DEFINES_VH
`define DCFG_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DCFG_ADDR_TIMER_CONTROL    8'h84
`define DCFG_ADDR_TIMER_RSVD       8'h85
`define DCFG_ADDR_TIMER_LOW        8'h86
`define DCFG_ADDR_TIMER_HIGH       8'h87
`define DCFG_ADDR_SAMPLING         8'h88
`define DCFG_ADDR_ANCILLARY_RSVD   8'h89
`define DCFG_ADDR_SOFT_RESET       8'h8a
`define DCFG_ADDR_SLEEP            8'h8b
`define DCFG_ADDR_REVISION         8'h8c
`define DCFG_ADDR_IDENTIFIER       8'h8d
`define DCFG_ADDR_BCAST_EEPROM     8'h8e
`define DCFG_ADDR_PIN_INT_EN       8'h8f
`define DCFG_ADDR_PIN_LEVEL        8'h90
`define DCFG_ADDR_PIN_TRISTATE     8'h91
`define DCFG_ADDR_PIN_INVERT       8'h92
`define DCFG_ADDR_PIN_DIRECTION    8'h93

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DCFG_TC_INT_EN             0
`define DCFG_TC_RUN                1
`define DCFG_TC_ONE_SHOT           2
`define DCFG_TC_EXT_CLK            3
`define DCFG_TC_ROUTE_PIN0         4
`define DCFG_TC_USED_MASK          8'h1f
// broadcast/eeprom byte: bits 16..23 of the dword land on 0..7
`define DCFG_BE_BROADCAST          0
`define DCFG_BE_EE_CLOCK           4
`define DCFG_BE_EE_SELECT          5
`define DCFG_BE_EE_DATA_TO         6
`define DCFG_BE_EE_DATA_FROM       7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DCFG_RST_BYTE_ZERO         8'h00
`define DCFG_RST_PIN_DIRECTION     8'hff
`define DCFG_RST_TIMER_VALUE       16'h0000

// ----------------------------------------------------------------
// channel 0 interrupt source codes
// ----------------------------------------------------------------
`define DCFG_CODE_NONE             3'h0
`define DCFG_CODE_PIN              3'h6
`define DCFG_CODE_TIMER            3'h7

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DCFG_WAKE_CRYSTAL_CLOCKS   6'h20

`endif

/* rtl/dcfg_timer.v */
// sixteen-bit down-counting timer core with reload and one-shot option
`timescale 1ns/1ps
module dcfg_timer (
    // clock and reset
    input  wire        clk_sys,
    input  wire        rst,
    // control
    input  wire        count_tick,
    input  wire        run,
    input  wire        one_shot,
    input  wire        restart,
    input  wire [15:0] reload,
    // event
    output reg         timeout_reg
);
`include "dcfg_defines.vh"

    reg  [15:0] count_reg;
    reg         spent_reg;

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    // a restart reloads and re-arms; a spent one-shot holds until then
    always @(posedge clk_sys) begin
        if (rst) begin
            count_reg   <= `DCFG_RST_TIMER_VALUE;
            spent_reg   <= 1'b0;
            timeout_reg <= 1'b0;
        end else begin
            timeout_reg <= 1'b0;
            if (restart) begin
                count_reg <= reload;
                spent_reg <= 1'b0;
            end else if (run && !spent_reg && count_tick) begin
                if (count_reg == 16'h0000 || count_reg == 16'h0001) begin
                    timeout_reg <= 1'b1;
                    count_reg   <= reload;
                    spent_reg   <= one_shot;
                end else begin
                    count_reg <= count_reg - 16'h0001;
                end
            end
        end
    end

endmodule

/* tb/dcfg_chk.sv */
// port assertions for the configuration block
`timescale 1ns/1ps
module dcfg_chk (
    // clock, reset and register port
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // block outputs and sleep status
    input wire logic [7:0] sampling_rate_select,
    input wire logic [7:0] channel_reset_pulse,
    input wire logic [2:0] chan0_int_code,
    input wire logic asleep,
    input wire logic oscillator_enable,
    input wire logic [7:0] chan_int_pending
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    ctl_read_a: assert property (reg_rd&&reg_addr==8'h84 |=> reg_rdata[7:5]==3'h0) else $error("ctl");
    rsvd_read_a: assert property (reg_rd&&reg_addr==8'h85 |=> reg_rdata==8'h00) else $error("rsvd");
    rate_write_a: assert property (reg_wr&&reg_addr==8'h88 |=>
        sampling_rate_select==$past(reg_wdata)) else $error("rate");
    reset_pulse_a: assert property (reg_wr&&reg_addr==8'h8a |=>
        channel_reset_pulse==$past(reg_wdata)) else $error("pulse");
    reset_clear_a: assert property (!(reg_wr&&reg_addr==8'h8a) |=>
        channel_reset_pulse==8'h00) else $error("stuck");
    code_set_a: assert property (chan0_int_code==3'h0||chan0_int_code>3'h5) else $error("code");
    osc_stop_a: assert property (asleep |-> !oscillator_enable) else $error("osc");
    sleep_idle_a: assert property ($rose(asleep) |-> $past(chan_int_pending)==8'h00) else $error("busy");
endmodule
bind dcfg_top dcfg_chk u_chk (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sampling_rate_select(sampling_rate_select),
    .channel_reset_pulse(channel_reset_pulse), .chan0_int_code(chan0_int_code), .asleep(asleep),
    .oscillator_enable(oscillator_enable), .chan_int_pending(chan_int_pending));

/* tb/dcfg_eeprom.sv */
// serial memory model on the eeprom port
`timescale 1ns/1ps
module dcfg_eeprom (
    input wire logic clk_sys,
    input wire logic eeprom_select_out,
    input wire logic eeprom_data_to_memory,
    output wire logic eeprom_data_from_memory
);
    logic last_bit=1'b0;
    // deselected output shows the inverse of its last level, so a stale sample reads wrong
    always @(posedge clk_sys) if (eeprom_select_out) last_bit<=~eeprom_data_to_memory;
    assign eeprom_data_from_memory=eeprom_select_out?~eeprom_data_to_memory:~last_bit;
endmodule

/* tb/testbench.sv */
// self-checking bench for the configuration block
`timescale 1ns/1ps
module testbench;
    logic clk_sys=0,rst=1,reg_wr=0,reg_rd=0,crystal_tick=0,external_timer_clock_pin=0,int_indicator_read=0;
    logic reg_rvalid,broadcast_write,asleep,oscillator_enable,device_ready,wake_interrupt;
    logic eeprom_clock_out,eeprom_select_out,eeprom_data_to_memory,eeprom_data_from_memory;
    logic [7:0] reg_addr=0,reg_wdata=0,chan_int_pending=0,divisor_nonzero=8'hff,rx_input=8'hff,tx_load=0;
    logic [7:0] modem_delta_flag=0,modem_input_change=0,multipurpose_pins_in=0,reg_rdata,sampling_rate_select;
    logic [7:0] channel_reset_pulse,multipurpose_pins_out,multipurpose_pins_oe;
    logic [2:0] chan0_int_code;
    int failures=0,checks=0,i;
    dcfg_top dut (.*);
    dcfg_eeprom u_ee (.*);
    // crystal enable every other cycle, held low while the oscillator is stopped
    initial forever #25 clk_sys=~clk_sys;
    always @(posedge clk_sys) crystal_tick<=(rst||oscillator_enable)&&!crystal_tick;
    task ck(input [7:0] s,e);
        checks++;
        if (s!==e) begin failures++;$display("[ERR] %0t %h %h",$time,s,e); end
    endtask
    task wr(input [7:0] a,d);
        @(posedge clk_sys) {reg_addr,reg_wdata,reg_wr}<={a,d,1'b1};
        @(posedge clk_sys) reg_wr<=0;
    endtask
    task rd(input [7:0] a,e);
        @(posedge clk_sys) {reg_addr,reg_rd}<={a,1'b1};
        @(posedge clk_sys) reg_rd<=0;
        @(negedge clk_sys) ck(reg_rdata,e);
        ck(reg_rvalid,1);
    endtask
    task wt(input [2:0] c);
        for (i=0;i<300&&chan0_int_code!==c;i++) @(negedge clk_sys);
        ck(chan0_int_code,c);
    endtask
    task ws(input v);
        for (i=0;i<300&&asleep!==v;i++) @(negedge clk_sys);
        ck(asleep,v);
    endtask
    task t_regs;
        rd(8'h93,8'hff);rd(8'h86,0);wr(8'h8d,0);rd(8'h8d,8'h58);rd(8'h8c,8'h07);
        wr(8'h85,1);rd(8'h85,0);rd(8'h8a,0);wr(8'h88,8'ha5);rd(8'h88,8'ha5);
        ck(sampling_rate_select,8'ha5);wr(8'h8a,8'h81);
        @(negedge clk_sys);ck(channel_reset_pulse,8'h81);
        @(negedge clk_sys);ck(channel_reset_pulse,8'h00);
    endtask
    task t_timer;
        wr(8'h86,3);wr(8'h84,8'he7);rd(8'h84,8'h07);wt(7);rd(8'h84,8'h07);wt(0);
        repeat(40) @(negedge clk_sys);ck(chan0_int_code,0);
        wr(8'h84,3);wt(7);rd(8'h84,3);wt(0);wt(7);
        wr(8'h84,1);rd(8'h84,1);wt(0);repeat(20) @(negedge clk_sys);ck(chan0_int_code,0);
    endtask
    // external timer clock: crystal ticks must be ignored, pin edges counted
    task t_ext;
        wr(8'h93,8'hfe);wr(8'h84,8'h1f);repeat(20) @(negedge clk_sys);ck(chan0_int_code,0);
        repeat(3) begin
            @(posedge clk_sys) external_timer_clock_pin<=1;
            @(posedge clk_sys) external_timer_clock_pin<=0;
        end
        wt(7);ck(multipurpose_pins_out[0],1);
        rd(8'h84,8'h1f);wt(0);ck(multipurpose_pins_out[0],0);wr(8'h84,0);
    endtask
    task t_pins;
        wr(8'h93,8'hfe);wr(8'h90,3);@(negedge clk_sys);ck(multipurpose_pins_oe,1);
        @(negedge clk_sys);ck(multipurpose_pins_out[0],1);
        wr(8'h91,1);repeat(2) @(negedge clk_sys);ck(multipurpose_pins_oe,0);
        wr(8'h8f,2);@(posedge clk_sys) multipurpose_pins_in<=2;wt(6);rd(8'h90,3);wt(0);
        wr(8'h92,2);rd(8'h90,1);
    endtask
    task t_eeprom;
        wr(8'h8e,8'h71);@(negedge clk_sys);
        ck({eeprom_data_to_memory,eeprom_select_out,eeprom_clock_out,broadcast_write},8'h0f);
        rd(8'h8e,8'h01);wr(8'h8e,8'h20);rd(8'h8e,8'h80);
        wr(8'h8e,8'h00);rd(8'h8e,8'h00);
    endtask
    task t_sleep;
        wr(8'h8b,8'hff);ws(1);ck(oscillator_enable,0);@(posedge clk_sys) tx_load<=1;
        @(posedge clk_sys) tx_load<=0;ws(0);ck(wake_interrupt,1);ck(device_ready,0);
        // 32 crystal ticks at one tick per two clocks
        for (i=0;i<200&&device_ready!==1;i++) @(negedge clk_sys);
        ck(i,64);
        @(posedge clk_sys) {chan_int_pending,int_indicator_read}<=9'h1ff;
        @(posedge clk_sys) int_indicator_read<=0;
        repeat(9) @(negedge clk_sys);ck(asleep|wake_interrupt,0);
        @(posedge clk_sys) chan_int_pending<=0;ws(1);
    endtask
    initial begin
        repeat(16) @(posedge clk_sys);
        rst<=0;
        t_regs;t_timer;t_ext;t_pins;t_eeprom;t_sleep;stop_test;
    end
    // watchdog at several times the expected run
    initial begin #400000;failures++;stop_test; end
    task stop_test;
        $display("checks %0d failures %0d",checks,failures);
        if (failures==0&&checks>0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
endmodule
